// File: rtl/sarx_top.sv
// Purpose: receive side of the primary serial audio port with latch config
// Assumes: pins are asynchronous to pclk, bit clock well below pclk/4
// Notes: registers on APB with no wait state, registered read data
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "sarx_defs.svh"
module sarx_top
   import sarx_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic bclk_in,
   output logic bclk_out,
   output logic bclk_oe_n,
   input wire logic frame_sync_in,
   output logic frame_sync_out,
   output logic frame_sync_oe_n,
   input wire logic din_primary,
   input wire logic din_secondary,
   output logic [31:0] rx_word_primary,
   output logic [31:0] rx_word_secondary,
   output logic rx_word_valid,
   output logic [4:0] rx_slot,
   output logic rx_right
);
   localparam logic [4:0] DIV_LAST = 5'(`SARX_BCLK_HALF_NS / `SARX_PCLK_NS - 1);

   sarx_top_s q;
   sarx_top_s d;
   logic [1:0] dword_done;
   logic [31:0] dword [2];

   // decoded configuration
   logic ctrlr_w;
   logic fsint_w;
   logic bcint_w;
   logic lat_pol_w;
   sarx_fmt_e fmt_w;
   logic [5:0] wl_w;
   logic [5:0] pos_w;
   logic bclk_sel_w;
   logic fs_sel_w;
   logic sample_w;
   logic boundary_w;
   logic [5:0] cnt_now_w;
   logic start_w;
   logic [5:0] idx_w;
   logic last_w;
   logic [7:0] ridx_w;

   always_comb begin
      ctrlr_w = q.ctl[`SARX_CTL_CTRLR_BIT];
      fsint_w = q.latch_cfg[`SARX_FSINT_BIT];
      bcint_w = q.latch_cfg[`SARX_BCINT_BIT];
      fmt_w = sarx_fmt_e'(q.ctl[`SARX_CTL_FMT_MSB:`SARX_CTL_FMT_LSB]);
      unique case (q.ctl[`SARX_CTL_WL_MSB:`SARX_CTL_WL_LSB])
         2'h0: wl_w = `SARX_WL16;
         2'h1: wl_w = `SARX_WL20;
         2'h2: wl_w = `SARX_WL24;
         2'h3: wl_w = `SARX_WL32;
      endcase
   end

   assign bclk_sel_w = (ctrlr_w && bcint_w) ? q.ibclk : q.bclk_s;
   assign fs_sel_w = (ctrlr_w && fsint_w) ? q.ifs : q.fs_s;
   assign lat_pol_w = q.ctl[`SARX_CTL_POL_BIT] ^ q.latch_cfg[`SARX_EDGE_BIT];
   assign sample_w = lat_pol_w ? (q.bclk_prev && !bclk_sel_w) : (!q.bclk_prev && bclk_sel_w);

   // frame and half-frame boundaries seen at a latch edge
   assign boundary_w = sample_w && ((fmt_w == SARX_FMT_TDM) ? (fs_sel_w && !q.fs_lat) : (fs_sel_w != q.fs_lat));
   assign cnt_now_w = boundary_w ? 6'h00 : ((q.cnt == `SARX_CNT_MAX) ? q.cnt : q.cnt + 6'h01);
   // MSB expected at protocol position plus offset
   assign pos_w = {1'b0, q.latch_cfg[`SARX_OFS_MSB:`SARX_OFS_LSB]} + {5'h00, fmt_w == SARX_FMT_I2S};
   // a frame boundary ends any slot run, so a stale run never starts or ends a word there
   assign start_w = sample_w && ((cnt_now_w == pos_w) ||
      (q.run && !boundary_w && fmt_w == SARX_FMT_TDM && q.sbit == wl_w));
   assign idx_w = start_w ? 6'h00 : q.sbit;
   assign last_w = sample_w && (start_w || (q.run && !boundary_w)) && (idx_w == wl_w - 6'h01);
   assign ridx_w = paddr[9:2];

   // next state of pins, receiver, clock generator and registers
   always_comb begin
      d = q;
      // two flops on every pin before use
      d.bclk_m = bclk_in;
      d.bclk_s = q.bclk_m;
      d.fs_m = frame_sync_in;
      d.fs_s = q.fs_m;
      d.din_m = {din_secondary, din_primary};
      d.din_s = q.din_m;
      d.bclk_prev = bclk_sel_w;

      if (sample_w) begin
         d.fs_lat = fs_sel_w;
         d.cnt = cnt_now_w;
         if (boundary_w) begin
            d.run = 1'b0;
            d.slot = 5'h00;
            d.right = (fmt_w == SARX_FMT_I2S) ? fs_sel_w : ((fmt_w == SARX_FMT_LJ) && !fs_sel_w);
         end
         if (start_w) begin
            d.run = 1'b1;
            if (q.run && !boundary_w) begin
               d.slot = q.slot + 5'h01;
            end
         end else if (last_w && fmt_w != SARX_FMT_TDM) begin
            d.run = 1'b0;
         end
         if (start_w || q.run) begin
            d.sbit = idx_w + 6'h01;
         end
         if (last_w) begin
            d.slot_out = d.slot;
            d.right_out = d.right;
         end
      end

      // internal bit clock and frame sync, frame sync moves on the falling edge
      d.div = (q.div == DIV_LAST) ? 5'h00 : q.div + 5'h01;
      if (q.div == DIV_LAST) begin
         d.ibclk = !q.ibclk;
         if (q.ibclk) begin
            d.iframe = (q.iframe == `SARX_FRAME_BCLKS) ? 6'h00 : q.iframe + 6'h01;
            unique case (fmt_w)
               SARX_FMT_TDM: d.ifs = (d.iframe == 6'h00);
               SARX_FMT_I2S: d.ifs = (d.iframe >= `SARX_HALF_FRAME);
               SARX_FMT_LJ: d.ifs = (d.iframe < `SARX_HALF_FRAME);
               default: d.ifs = 1'b0;
            endcase
         end
      end
      d.pin_oe_n = !ctrlr_w;

      // apb: read data and ready prepared in setup, taken in access
      d.pready = psel && !penable;
      if (psel && !penable) begin
         d.pslverr = 1'b0;
         d.prdata = 32'h0000_0000;
         unique case (ridx_w)
            `SARX_IDX_RX_LATCH: d.prdata = {24'h00_0000, q.latch_cfg};
            `SARX_IDX_CLOCK_CONFIG_ZERO: d.prdata = {24'h00_0000, q.clock_config_zero};
            `SARX_IDX_RX_CTRL: d.prdata = {24'h00_0000, q.ctl};
            `SARX_IDX_RX_DATA0: d.prdata = dword[0];
            `SARX_IDX_RX_DATA1: d.prdata = dword[1];
            `SARX_IDX_RX_STAT: d.prdata = {25'h000_0000, q.run, q.right_out, q.slot_out};
            default: d.pslverr = 1'b1;
         endcase
         if (pwrite && (ridx_w == `SARX_IDX_RX_DATA0 || ridx_w == `SARX_IDX_RX_DATA1 || ridx_w == `SARX_IDX_RX_STAT)) begin
            d.pslverr = 1'b1;
         end
      end
      if (psel && penable && q.pready && pwrite) begin
         if (ridx_w == `SARX_IDX_RX_LATCH) d.latch_cfg = pwdata[7:0];
         if (ridx_w == `SARX_IDX_CLOCK_CONFIG_ZERO) d.clock_config_zero = pwdata[7:0];
         if (ridx_w == `SARX_IDX_RX_CTRL) d.ctl = pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.latch_cfg <= `SARX_RST_RX_LATCH;
         q.clock_config_zero <= `SARX_RST_CLOCK_CONFIG_ZERO;
         q.ctl <= `SARX_RST_RX_CTRL;
         q.pin_oe_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // same framing drives both data pins
   for (genvar i = 0; i < 2; i++) begin : g_pin
      sarx_deser u_deser (
         .pclk(pclk),
         .presetn(presetn),
         .sample(sample_w),
         .start(start_w),
         .last(last_w),
         .din(q.din_s[i]),
         .word(dword[i]),
         .done(dword_done[i])
      );
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign bclk_out = q.ibclk;
   assign bclk_oe_n = q.pin_oe_n;
   assign frame_sync_out = q.ifs;
   assign frame_sync_oe_n = q.pin_oe_n;
   assign rx_word_primary = dword[0];
   assign rx_word_secondary = dword[1];
   assign rx_word_valid = dword_done[0];
   assign rx_slot = q.slot_out;
   assign rx_right = q.right_out;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   edge_select_a: assert property (sample_w |-> (bclk_sel_w == !lat_pol_w) && (q.bclk_prev == lat_pol_w))
      else $error("latch taken on wrong bit clock edge");
   frame_sync_source_a: assert property (fs_sel_w == ((ctrlr_w && fsint_w) ? q.ifs : q.fs_s))
      else $error("frame sync source does not follow select");
   bclk_source_a: assert property (!(ctrlr_w && bcint_w) |-> bclk_sel_w == q.bclk_s)
      else $error("external bit clock not used");
   msb_zero_a: assert property ((boundary_w && pos_w == 6'h00) |-> start_w)
      else $error("zero offset MSB not on boundary");
   msb_late_a: assert property ((boundary_w && pos_w != 6'h00) |-> !start_w)
      else $error("offset MSB taken too early");
   both_pins_a: assert property (dword_done[0] == dword_done[1])
      else $error("data pins framed differently");
   apb_ready_a: assert property ((psel && !penable) |=> pready ##1 !pready)
      else $error("apb ready not one cycle after setup");
endmodule : sarx_top

// File: common/sarx_defs.svh
// Purpose: constants of the serial audio receive latch block
// Assumes: 32-bit APB, word registers, register index times four is the byte address
// Notes: register indices kept as printed, fields as bit positions
// Function
// - latch bit one selects opposite, later edge
// - controller mode: frame sync internal or external
// - controller mode: bit clock internal or external
// - delay slot-0 MSB by 0..31 cycles
// - offset covers both pins, all slot 0s
`ifndef SARX_DEFS_SVH
`define SARX_DEFS_SVH

// register indices, byte address is index times four
`define SARX_IDX_RX_LATCH 8'h26
`define SARX_IDX_CLOCK_CONFIG_ZERO 8'h32
`define SARX_IDX_RX_CTRL 8'h40
`define SARX_IDX_RX_DATA0 8'h41
`define SARX_IDX_RX_DATA1 8'h42
`define SARX_IDX_RX_STAT 8'h43

// reset values
`define SARX_RST_RX_LATCH 8'h00
`define SARX_RST_CLOCK_CONFIG_ZERO 8'h00
`define SARX_RST_RX_CTRL 8'h00

// latch config fields
`define SARX_EDGE_BIT 7
`define SARX_FSINT_BIT 6
`define SARX_BCINT_BIT 5
`define SARX_OFS_MSB 4
`define SARX_OFS_LSB 0

// own control fields
`define SARX_CTL_CTRLR_BIT 0
`define SARX_CTL_POL_BIT 1
`define SARX_CTL_FMT_MSB 3
`define SARX_CTL_FMT_LSB 2
`define SARX_CTL_WL_MSB 5
`define SARX_CTL_WL_LSB 4

// word lengths in bits
`define SARX_WL16 6'h10
`define SARX_WL20 6'h14
`define SARX_WL24 6'h18
`define SARX_WL32 6'h20

// internal clock generation
`define SARX_PCLK_NS 4
`define SARX_BCLK_HALF_NS 40
`define SARX_FRAME_BCLKS 6'h3F
`define SARX_HALF_FRAME 6'h20
`define SARX_CNT_MAX 6'h3F

`endif

// File: common/sarx_pkg.sv
// Purpose: types of the serial audio receive latch block
// Assumes: sarx_defs.svh holds every number but the format codes, which stand in this package
// Notes: one packed struct per module holds all its state
package sarx_pkg;

   // serial formats, left justified last
   typedef enum logic [1:0] {
      SARX_FMT_TDM = 2'h0,
      SARX_FMT_I2S = 2'h1,
      SARX_FMT_LJ = 2'h3
   } sarx_fmt_e;

   typedef struct packed {
      logic [31:0] sh;
      logic [31:0] word;
      logic done;
   } sarx_deser_s;

   typedef struct packed {
      logic bclk_m;
      logic bclk_s;
      logic fs_m;
      logic fs_s;
      logic [1:0] din_m;
      logic [1:0] din_s;
      logic bclk_prev;
      logic fs_lat;
      logic [5:0] cnt;
      logic [5:0] sbit;
      logic run;
      logic [4:0] slot;
      logic right;
      logic [7:0] latch_cfg;
      logic [7:0] clock_config_zero;
      logic [7:0] ctl;
      logic [4:0] div;
      logic ibclk;
      logic [5:0] iframe;
      logic ifs;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [4:0] slot_out;
      logic right_out;
      logic pin_oe_n;
   } sarx_top_s;

endpackage : sarx_pkg

// File: rtl/sarx_deser.sv
// Purpose: shift one serial data pin into words
// Assumes: sample, start and last come from the top on pclk
// Notes: words are right aligned, first bit in is the MSB
`timescale 1ns/1ps
module sarx_deser
   import sarx_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sample,
   input wire logic start,
   input wire logic last,
   input wire logic din,
   output logic [31:0] word,
   output logic done
);
   sarx_deser_s q;
   sarx_deser_s d;

   // shift on each latch sample, a start clears older bits
   always_comb begin
      d = q;
      d.done = 1'b0;
      if (sample) begin
         d.sh = start ? {31'h0000_0000, din} : {q.sh[30:0], din};
         if (last) begin
            d.word = d.sh;
            d.done = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign word = q.word;
   assign done = q.done;
endmodule : sarx_deser

// File: verif/sarx_host_model.sv
// Purpose: host serial port streaming left justified, I2S and TDM frames
// Assumes: 80 ns bit clock, still between frames, LJ frame_sync high = left half
// Notes: bits outside the words toggle so stale data never passes
`timescale 1ns/1ps
module sarx_host_model
   import sarx_pkg::*;
#(
   parameter int HALF_BCLKS = 48
)(
   output logic bclk,
   output logic frame_sync,
   output logic dp,
   output logic ds
);
   initial begin
      bclk = 1'h0;
      frame_sync = 1'h0;
      dp = 1'h0;
      ds = 1'h0;
   end

   // msb at offset, data stable around latch edge
   // data moves with the non-latch edge, so a receiver on the wrong edge sees the next bit
   task automatic frame(input logic inv, input sarx_fmt_e fm, input int ofs, input logic [63:0] w);
      int pos;
      int n;
      logic tdm;
      logic i2s;
      tdm = (fm == SARX_FMT_TDM);
      i2s = (fm == SARX_FMT_I2S);
      n = tdm ? ofs + 32 : HALF_BCLKS;
      bclk <= inv;
      #80;
      for (int h = 0; h < (tdm ? 1 : 2); h++) begin
         // one lead-in bit drives the idle sync level, high for I2S and low for LJ and TDM, the stopped clock left it unlatched
         for (int k = (h == 0) ? -1 : 0; k < n; k++) begin
            pos = k - ofs - int'(i2s);
            if (k < 0) begin
               frame_sync <= tdm ? 1'h0 : i2s;
            end else begin
               frame_sync <= tdm ? (k == 0) : ((h == 0) ^ i2s);
            end
            dp <= (pos >= 0 && pos < (tdm ? 32 : 16)) ? w[63 - 32 * h - pos] : ~dp;
            ds <= (pos >= 0 && pos < (tdm ? 32 : 16)) ? w[(tdm ? 31 : 47 - 32 * h) - pos] : ~ds;
            bclk <= inv;
            #40 bclk <= ~inv;
            #40;
         end
      end
      // released lines show the inverse, clock parks on its idle level
      bclk <= inv;
      dp <= ~dp;
      ds <= ~ds;
   endtask : frame

   task automatic hold(input logic a, input logic b);
      dp <= a;
      ds <= b;
   endtask : hold
endmodule : sarx_host_model

// File: verif/sarx_top_tb.sv
// Purpose: self-checking bench of the receive latch block
// Assumes: host model drives the link pins, bench drives APB
// Notes: expected results queue up, monitors pop them as results appear
`timescale 1ns/1ps
`include "sarx_defs.svh"
module sarx_top_tb
   import sarx_pkg::*;
;
   localparam logic [11:0] A_LAT = {2'h0, `SARX_IDX_RX_LATCH, 2'h0};
   localparam logic [11:0] A_CLK = {2'h0, `SARX_IDX_CLOCK_CONFIG_ZERO, 2'h0};
   localparam logic [11:0] A_CTL = {2'h0, `SARX_IDX_RX_CTRL, 2'h0};
   localparam logic [11:0] A_D0 = {2'h0, `SARX_IDX_RX_DATA0, 2'h0};
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rx_p, rx_s;
   logic pready, pslverr, bclk_out, bclk_oe_n, fs_out, fs_oe_n, rx_valid, rx_right;
   logic bclk, frame_sync, dp, ds, free_run = 1'h0;
   logic [4:0] rx_slot;
   logic [33:0] ae;
   logic [37:0] re;
   logic [33:0] apb_q[$];
   logic [37:0] rx_q[$];
   int failures = 0, n_tests = 0, cyc = 0, npulse = 0;
   int bc_n = 0, fs_n = 0;
   logic bc_l = 1'h0, fs_l = 1'h0, bc_ok = 1'h0, fs_ok = 1'h0;

   always #2 pclk = ~pclk;

   sarx_top DUT(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bclk_in(bclk), .bclk_out(bclk_out), .bclk_oe_n(bclk_oe_n), .frame_sync_in(frame_sync),
      .frame_sync_out(fs_out), .frame_sync_oe_n(fs_oe_n), .din_primary(dp), .din_secondary(ds),
      .rx_word_primary(rx_p), .rx_word_secondary(rx_s), .rx_word_valid(rx_valid),
      .rx_slot(rx_slot), .rx_right(rx_right));

   sarx_host_model HOST(.bclk(bclk), .frame_sync(frame_sync), .dp(dp), .ds(ds));

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   task final_report;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : final_report

   // one transfer, held until pready is seen high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e, input logic er);
      apb_q.push_back({w, er, e});
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   // bus answers against the oldest note
   always @(posedge pclk) if (presetn && pready === 1'h1) begin
      if (apb_q.size() == 0) chk("apb answer", 32'h0, 32'h1);
      else begin
         ae = apb_q.pop_front();
         chk("pslverr", {31'h0, ae[32]}, {31'h0, pslverr});
         if (!ae[33]) chk("prdata", ae[31:0], prdata);
      end
   end

   // received words against the oldest note
   always @(posedge pclk) if (presetn && rx_valid === 1'h1) begin
      if (free_run) begin
         npulse++;
         chk("internal primary", 32'h0000FFFF, rx_p);
         chk("internal secondary", 32'h0, rx_s);
      end else if (rx_q.size() == 0) chk("unexpected word", 32'h0, 32'h1);
      else begin
         re = rx_q.pop_front();
         chk("rx_slot", {27'h0, re[37:33]}, {27'h0, rx_slot});
         chk("rx_right", {31'h0, re[32]}, {31'h0, rx_right});
         chk("primary word", {16'h0, re[31:16]}, rx_p);
         chk("secondary word", {16'h0, re[15:0]}, rx_s);
      end
   end

   // internal clock and frame sync spacing while the block drives them
   always @(posedge pclk) begin
      if (free_run && bclk_out !== bc_l) begin
         if (bc_ok) chk("bclk_out half period", `SARX_BCLK_HALF_NS / `SARX_PCLK_NS, bc_n);
         bc_ok = 1'h1;
         bc_n = 0;
      end
      if (free_run && fs_out !== fs_l) begin
         if (fs_ok) chk("frame_sync_out half", `SARX_HALF_FRAME * 2 * `SARX_BCLK_HALF_NS / `SARX_PCLK_NS, fs_n);
         fs_ok = 1'h1;
         fs_n = 0;
      end
      bc_n++;
      fs_n++;
      bc_l = bclk_out;
      fs_l = fs_out;
   end

   // hang guard, well above the planned run
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         failures++;
         $display("timeout after %0d cycles", cyc);
         final_report();
      end
   end

   initial begin : main
      logic [15:0] w[4];
      int ofs;
      logic [7:0] v;
      sarx_fmt_e fm;
      void'($urandom(55));
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, A_LAT, 32'h0, {24'h0, `SARX_RST_RX_LATCH}, 1'h0);
      apb(1'h0, A_CLK, 32'h0, {24'h0, `SARX_RST_CLOCK_CONFIG_ZERO}, 1'h0);
      apb(1'h0, A_CTL, 32'h0, {24'h0, `SARX_RST_RX_CTRL}, 1'h0);
      v = $urandom;
      // upper bits are dropped, back to back write then read
      apb(1'h1, A_LAT, {24'hA5A5A5, v}, 32'h0, 1'h0);
      apb(1'h0, A_LAT, 32'h0, {24'h0, v}, 1'h0);
      apb(1'h1, A_CLK, {24'h0, ~v}, 32'h0, 1'h0);
      apb(1'h0, A_CLK, 32'h0, {24'h0, ~v}, 1'h0);
      apb(1'h0, 12'h140, 32'h0, 32'h0, 1'h1);
      apb(1'h1, A_D0, 32'h1, 32'h0, 1'h1);
      $display("test registers done");
      // all polarity and invert pairs, offsets 0, 31 and random, LJ, I2S and TDM
      for (int i = 0; i < 4; i++) begin
         ofs = (i == 0) ? 0 : (i == 1) ? 31 : $urandom_range(30, 1);
         fm = (i == 1) ? SARX_FMT_I2S : (i == 2) ? SARX_FMT_TDM : SARX_FMT_LJ;
         foreach (w[k]) w[k] = $urandom;
         apb(1'h1, A_CTL, {26'h0, 2'h0, fm, i[1], i == 3}, 32'h0, 1'h0);
         apb(1'h1, A_LAT, {24'h0, i[0], 2'h0, ofs[4:0]}, 32'h0, 1'h0);
         apb(1'h0, A_LAT, 32'h0, {24'h0, i[0], 2'h0, ofs[4:0]}, 1'h0);
         if (fm == SARX_FMT_TDM) begin
            // two slots back to back, primary carries w0 then w1
            rx_q.push_back({5'h00, 1'h0, w[0], w[2]});
            rx_q.push_back({5'h01, 1'h0, w[1], w[3]});
         end else begin
            rx_q.push_back({5'h00, 1'h0, w[0], w[1]});
            rx_q.push_back({5'h00, 1'h1, w[2], w[3]});
         end
         HOST.frame(i[1] ^ i[0], fm, ofs, {w[0], w[1], w[2], w[3]});
         repeat (40) @(posedge pclk);
         chk("words left over", 32'h0, rx_q.size());
         $display("test link %0d done", i);
      end
      // internal clocks only, external pins silent
      HOST.hold(1'h1, 1'h0);
      apb(1'h1, A_CTL, 32'h0000000D, 32'h0, 1'h0);
      apb(1'h1, A_LAT, 32'h00000065, 32'h0, 1'h0);
      free_run <= 1'h1;
      repeat (3000) @(posedge pclk);
      chk("bclk_oe_n", 32'h0, {31'h0, bclk_oe_n});
      chk("frame_sync_oe_n", 32'h0, {31'h0, fs_oe_n});
      chk("internal pulses", 32'h1, {31'h0, npulse >= 2});
      apb(1'h1, A_CTL, 32'h0000000C, 32'h0, 1'h0);
      repeat (20) @(posedge pclk);
      chk("bclk_oe_n off", 32'h1, {31'h0, bclk_oe_n});
      chk("frame_sync_oe_n off", 32'h1, {31'h0, fs_oe_n});
      free_run <= 1'h0;
      $display("test controller done");
      final_report();
   end
endmodule : sarx_top_tb
